// >>> pin_board_model.sv
// Board model for the multi-purpose pins: external drivers, weak resistors, floating lines
`timescale 1ns/1ps
`default_nettype none
module pin_board_model #(
  parameter int N = 8
) (
  input  wire logic         core_clk,
  input  wire logic [N-1:0] pin_out,
  input  wire logic [N-1:0] pin_oe,
  input  wire logic [N-1:0] pin_pull_up,
  input  wire logic [N-1:0] pin_pull_down,
  input  wire logic [N-1:0] ext_en,
  input  wire logic [N-1:0] ext_val,
  output logic      [N-1:0] pin_in
);
  logic [N-1:0] float_r = '0;
  logic [N-1:0] float_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // An undriven, unpulled line flips every cycle so a stale level never passes
  always_comb begin
    float_nxt = ~float_r;
  end

  always_ff @(posedge core_clk) begin
    float_r <= float_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Device drive wins, then the external driver, then the weak resistors
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                  pin_pull_up[i] ? 1'b1 : pin_pull_down[i] ? 1'b0 : float_r[i];
    end
  end
endmodule
`default_nettype wire

// >>> pin_cfg_pkg.sv
// Package: offsets, field positions, reset values and roles for the pin configuration block
// Contract
// - Bit 7 set turns pull-up off
// - Bit 6 enables pull-down only without pull-up
// - Output roles ignore both resistor settings
// - Receive-toggle codes 000/001/010 select gpio roles
// - Receive-toggle code 011 gives push-pull activity toggle
// - Carrier codes 00/01/10 select gpio roles
// - Call-alert codes 00/01/10 select gpio roles
// - Bit 5 blocks call-alert remote wakeup
// - Terminal-ready codes 000/001/010 select gpio roles
// - Codes 011/100 drive modem terminal-ready output
// - Each channel owns readable writable register copies
package pin_cfg_pkg;

  localparam int NUM_CH   = 2;
  localparam int NUM_PINS = 4;
  localparam int NUM_REGS = NUM_CH * NUM_PINS;

  // Pin slots within a channel
  localparam int SLOT_TOGGLE  = 0;
  localparam int SLOT_CARRIER = 1;
  localparam int SLOT_ALERT   = 2;
  localparam int SLOT_TERM    = 3;

  // Register byte offsets, index = channel * 4 + slot
  localparam logic [7:0] CFG_OFFSET [NUM_REGS] = '{
    8'h29, 8'h2A, 8'h2B, 8'h2C,
    8'h3C, 8'h3D, 8'h3E, 8'h3F
  };

  // Field positions
  localparam int WEAK_HIGH_RESISTOR_OFF_BIT = 7;
  localparam int PULL_DOWN_ON_BIT           = 6;
  localparam int ALERT_WAKEUP_BLOCK_BIT     = 5;

  // Reset value and writable bits per slot; reserved bits are not stored
  localparam logic [7:0] CFG_RESET        = 8'h00;
  localparam logic [7:0] MASK_TOGGLE      = 8'hC3;
  localparam logic [7:0] MASK_CARRIER     = 8'hC3;
  localparam logic [7:0] MASK_ALERT       = 8'hE3;
  localparam logic [7:0] MASK_TERM        = 8'hC7;
  localparam logic [7:0] CFG_MASK [NUM_PINS] = '{
    MASK_TOGGLE, MASK_CARRIER, MASK_ALERT, MASK_TERM
  };

  // Function codes
  localparam logic [2:0] FN_GPIO_IN     = 3'h0;
  localparam logic [2:0] FN_GPIO_OD     = 3'h1;
  localparam logic [2:0] FN_GPIO_PP     = 3'h2;
  localparam logic [2:0] FN_TOGGLE_PP   = 3'h3;
  localparam logic [2:0] FN_TERM_OD     = 3'h3;
  localparam logic [2:0] FN_TERM_PP     = 3'h4;

  typedef enum logic [1:0] {
    ROLE_INPUT,
    ROLE_OPEN_DRAIN,
    ROLE_PUSH_PULL
  } role_type;

  typedef enum logic [1:0] {
    SRC_GPIO,
    SRC_TOGGLE,
    SRC_MODEM
  } source_type;

endpackage

// >>> pin_cfg_reg.sv
// One configuration register with writable-bit mask and clock enable
`timescale 1ns/1ps
`default_nettype none
module pin_cfg_reg #(
  parameter int         WIDTH = 8,
  parameter logic [7:0] MASK  = 8'hFF,
  parameter logic [7:0] RESET = pin_cfg_pkg::CFG_RESET
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  input  wire logic             wr,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  // Reserved bits are never stored, so they read back as zero
  always_comb begin
    q_nxt = q_r;
    if (wr) begin
      q_nxt = wdata & MASK[WIDTH-1:0];
    end
  end

  // Reset wins over the enable so a frozen block still comes up clean
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q_r <= RESET[WIDTH-1:0];
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule
`default_nettype wire

// >>> pin_pad_ctrl.sv
// Pad control for one multi-purpose pin: drive, enable, pulls and input capture
`timescale 1ns/1ps
`default_nettype none
module pin_pad_ctrl (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic clk_en,
  input  wire logic is_out,
  input  wire logic open_drain,
  input  wire logic drive_val,
  input  wire logic pu_off,
  input  wire logic pd_on,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pu_en,
  output logic      pd_en,
  output logic      in_val
);

  logic out_r;
  logic out_nxt;
  logic oe_r;
  logic oe_nxt;
  logic in_r;
  logic in_nxt;

  // Open drain only pulls low; a high level is left to the board
  always_comb begin
    out_nxt = 1'b0;
    oe_nxt  = 1'b0;
    in_nxt  = pin_in;
    if (is_out) begin
      if (open_drain) begin
        out_nxt = 1'b0;
        oe_nxt  = ~drive_val;
      end else begin
        out_nxt = drive_val;
        oe_nxt  = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      out_r <= 1'b0;
      oe_r  <= 1'b0;
      in_r  <= 1'b0;
    end else if (clk_en) begin
      out_r <= out_nxt;
      oe_r  <= oe_nxt;
      in_r  <= in_nxt;
    end
  end

  // Pulls follow the config flops directly; outputs mask them off
  assign pu_en   = ~is_out & ~pu_off;
  assign pd_en   = ~is_out & pu_off & pd_on;
  assign pin_out = out_r;
  assign pin_oe  = oe_r;
  assign in_val  = in_r;

  pull_up_a: assert property (@(posedge core_clk) disable iff (srst)
    !is_out |-> (pu_en == !pu_off))
    else $error("pull-up does not follow its disable bit");
  pull_down_a: assert property (@(posedge core_clk) disable iff (srst)
    pd_en |-> (pu_off && pd_on && !pu_en))
    else $error("pull-down on while pull-up active or not requested");
  out_pulls_a: assert property (@(posedge core_clk) disable iff (srst)
    is_out |-> (!pu_en && !pd_en))
    else $error("resistor enabled on an output pin");
  od_drive_a: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && is_out && open_drain) |=> (!pin_out && (pin_oe == !$past(drive_val))))
    else $error("open-drain pin drove high or released wrongly");

endmodule
`default_nettype wire

// >>> uart_modem_pin_function_config_tb.sv
// Self-checking testbench for the UART pin-function configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module uart_modem_pin_function_config_tb;
  logic       core_clk;
  logic       srst;
  logic       clk_en;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [7:0] gpio_drive;
  logic [7:0] gpio_sense;
  logic [1:0] rx_activity;
  logic [1:0] modem_term_ready_n;
  logic       global_wake_en;
  logic [1:0] wake_request_n;
  logic [1:0] receive_activity_toggle;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] pin_pull_up;
  logic [7:0] pin_pull_down;
  logic [7:0] ext_en;
  logic [7:0] ext_val;
  int         cmp_count;
  int         bad_count;
  logic [7:0] pv  [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};
  logic [7:0] pue [4] = '{8'hFF, 8'hFF, 8'h00, 8'h00};
  logic [7:0] pde [4] = '{8'h00, 8'h00, 8'h00, 8'hFF};
  logic [7:0] oee [2] = '{8'hA5, 8'hFF};
  logic [7:0] oute[2] = '{8'h00, 8'h5A};

  uart_pin_cfg #(.NUM_CH(2)) i_dut (
    .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gpio_drive(gpio_drive), .gpio_sense(gpio_sense), .rx_activity(rx_activity),
    .modem_term_ready_n(modem_term_ready_n), .global_wake_en(global_wake_en),
    .wake_request_n(wake_request_n), .receive_activity_toggle(receive_activity_toggle),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
    .pin_pull_down(pin_pull_down)
  );

  pin_board_model #(.N(8)) i_board (
    .core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
    .pin_pull_down(pin_pull_down), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and bus tasks; every strobe is one cycle, launched just after an edge
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic reg_check(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHECK(reg_rdata, e)
  endtask

  task automatic write_all(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      reg_write(pin_cfg_pkg::CFG_OFFSET[i], d);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic test_done();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cmp_count = 0;
    bad_count = 0;
    srst = 1'b1;
    clk_en = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {gpio_drive, rx_activity, global_wake_en, ext_en, ext_val} = '0;
    modem_term_ready_n = 2'b11;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    settle(1);
    // Reset state: inputs with pull-ups, wake idle, all registers zero
    `CHECK(pin_pull_up, 8'hFF)
    `CHECK(pin_pull_down, 8'h00)
    `CHECK(pin_oe, 8'h00)
    `CHECK(wake_request_n, 2'b11)
    for (int i = 0; i < 8; i++) begin
      reg_check(pin_cfg_pkg::CFG_OFFSET[i], 8'h00);
    end
    // Reserved bits are not stored; the unmapped gap stays empty
    write_all(8'hFF);
    reg_write(8'h2D, 8'hFF);
    reg_check(8'h2D, 8'h00);
    for (int i = 0; i < 8; i++) begin
      reg_check(pin_cfg_pkg::CFG_OFFSET[i], pin_cfg_pkg::CFG_MASK[i % 4]);
    end
    // The two channel copies are independent
    reg_write(pin_cfg_pkg::CFG_OFFSET[0], 8'h00);
    reg_check(pin_cfg_pkg::CFG_OFFSET[0], 8'h00);
    reg_check(pin_cfg_pkg::CFG_OFFSET[4], pin_cfg_pkg::CFG_MASK[0]);
    // Resistor table on input roles; the board model shows the resulting level
    for (int k = 0; k < 4; k++) begin
      write_all(pv[k]);
      settle(2);
      `CHECK(pin_pull_up, pue[k])
      `CHECK(pin_pull_down, pde[k])
      if (k != 2) begin
        `CHECK(gpio_sense, pue[k])
      end
    end
    // Open-drain and push-pull roles ignore the resistor bits
    @(posedge core_clk);
    gpio_drive <= 8'h5A;
    for (int c = 0; c < 2; c++) begin
      write_all(8'hC0 | 8'(c + 1));
      settle(2);
      `CHECK(pin_pull_up, 8'h00)
      `CHECK(pin_pull_down, 8'h00)
      `CHECK(pin_oe, oee[c])
      `CHECK(pin_out, oute[c])
    end
    // Input role passes the external level through
    @(posedge core_clk);
    ext_en  <= 8'hFF;
    ext_val <= 8'h3C;
    write_all(8'h80);
    settle(2);
    `CHECK(pin_oe, 8'h00)
    `CHECK(gpio_sense, 8'h3C)
    @(posedge core_clk);
    ext_en <= 8'h00;
    // Receive-activity toggle: three events on both channels, then one on channel 0
    reg_write(pin_cfg_pkg::CFG_OFFSET[0], 8'h03);
    reg_write(pin_cfg_pkg::CFG_OFFSET[4], 8'h03);
    for (int n = 0; n < 4; n++) begin
      @(posedge core_clk);
      rx_activity <= (n == 3) ? 2'b01 : 2'b11;
      @(posedge core_clk);
      rx_activity <= 2'b00;
      settle(2);
      `CHECK(receive_activity_toggle, (n == 3) ? 2'b10 : 2'(n % 2 == 0 ? 3 : 0))
      `CHECK({pin_oe[4], pin_oe[0], pin_out[4], pin_out[0]}, {2'b11, (n == 3) ? 2'b10 : 2'(n % 2 == 0 ? 3 : 0)})
    end
    // Terminal-ready modem roles, open drain then push-pull
    @(posedge core_clk);
    modem_term_ready_n <= 2'b10;
    // Companion modem pins lie outside this block and stay as configured
    reg_write(pin_cfg_pkg::CFG_OFFSET[3], 8'h03);
    reg_write(pin_cfg_pkg::CFG_OFFSET[7], 8'h03);
    settle(2);
    `CHECK({pin_oe[7], pin_oe[3], pin_out[7], pin_out[3]}, 4'b0100)
    reg_write(pin_cfg_pkg::CFG_OFFSET[3], 8'h04);
    reg_write(pin_cfg_pkg::CFG_OFFSET[7], 8'h04);
    settle(2);
    `CHECK({pin_oe[7], pin_oe[3], pin_out[7], pin_out[3]}, 4'b1110)
    // Call-alert wakeup: allowed, blocked per channel, then gated globally
    write_all(8'h00);
    @(posedge core_clk);
    ext_en         <= 8'h44;
    ext_val        <= 8'h00;
    global_wake_en <= 1'b1;
    settle(3);
    `CHECK(wake_request_n, 2'b00)
    reg_write(pin_cfg_pkg::CFG_OFFSET[2], 8'h20);
    settle(3);
    `CHECK(wake_request_n, 2'b01)
    @(posedge core_clk);
    global_wake_en <= 1'b0;
    settle(3);
    `CHECK(wake_request_n, 2'b11)
    // A write while the clock enable is low is ignored
    @(posedge core_clk);
    clk_en <= 1'b0;
    reg_write(pin_cfg_pkg::CFG_OFFSET[1], 8'h41);
    @(posedge core_clk);
    clk_en <= 1'b1;
    reg_check(pin_cfg_pkg::CFG_OFFSET[1], 8'h00);
    // Write then read with no gap; read data stand for one cycle only
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= pin_cfg_pkg::CFG_OFFSET[6];
    reg_wdata <= 8'hFF;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHECK(reg_rdata, pin_cfg_pkg::MASK_ALERT)
    settle(1);
    `CHECK(reg_rdata, 8'h00)
    test_done();
  end
endmodule
`default_nettype wire

// >>> uart_pin_cfg.sv
// Pin-function configuration for four multi-purpose pins on each of two UART channels
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module uart_pin_cfg #(
  parameter int NUM_CH = pin_cfg_pkg::NUM_CH
) (
  input  wire logic                core_clk,
  input  wire logic                srst,
  input  wire logic                clk_en,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  input  wire logic [NUM_CH*4-1:0] gpio_drive,
  output logic      [NUM_CH*4-1:0] gpio_sense,
  input  wire logic [NUM_CH-1:0]   rx_activity,
  input  wire logic [NUM_CH-1:0]   modem_term_ready_n,
  input  wire logic                global_wake_en,
  output logic      [NUM_CH-1:0]   wake_request_n,
  output logic      [NUM_CH-1:0]   receive_activity_toggle,
  input  wire logic [NUM_CH*4-1:0] pin_in,
  output logic      [NUM_CH*4-1:0] pin_out,
  output logic      [NUM_CH*4-1:0] pin_oe,
  output logic      [NUM_CH*4-1:0] pin_pull_up,
  output logic      [NUM_CH*4-1:0] pin_pull_down
);

  localparam int NREG = NUM_CH * pin_cfg_pkg::NUM_PINS;

  logic [7:0]                 cfg      [NREG];
  logic [NREG-1:0]            reg_hit;
  pin_cfg_pkg::role_type      role     [NREG];
  pin_cfg_pkg::source_type    src      [NREG];
  logic [NREG-1:0]            is_out;
  logic [NREG-1:0]            open_drain;
  logic [NREG-1:0]            drive_val;
  logic [7:0]                 rdata_r;
  logic [7:0]                 rdata_nxt;
  logic [NUM_CH-1:0]          toggle_r;
  logic [NUM_CH-1:0]          toggle_nxt;
  logic [NUM_CH-1:0]          wake_n_r;
  logic [NUM_CH-1:0]          wake_n_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  // Each channel has its own copy at its own offset
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      reg_hit[i] = (reg_addr == pin_cfg_pkg::CFG_OFFSET[i]);
    end
  end

  for (genvar g = 0; g < NREG; g++) begin : g_reg
    pin_cfg_reg #(
      .WIDTH (8),
      .MASK  (pin_cfg_pkg::CFG_MASK[g % pin_cfg_pkg::NUM_PINS]),
      .RESET (pin_cfg_pkg::CFG_RESET)
    ) u_reg (
      .core_clk (core_clk),
      .srst     (srst),
      .clk_en   (clk_en),
      .wr       (reg_wr & reg_hit[g]),
      .wdata    (reg_wdata),
      .q        (cfg[g])
    );
  end

  // Read data stands in the cycle after the strobe only; unmapped reads give zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      for (int i = 0; i < NREG; i++) begin
        if (reg_hit[i]) begin
          rdata_nxt = cfg[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_r <= 8'h00;
    end else if (clk_en) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // Function decode

  // Codes that software must not use fall back to input, the harmless role
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      role[i] = pin_cfg_pkg::ROLE_INPUT;
      src[i]  = pin_cfg_pkg::SRC_GPIO;
      case (i % pin_cfg_pkg::NUM_PINS)
        pin_cfg_pkg::SLOT_TOGGLE: begin
          // Only the low two bits are stored; 011 maps onto them one to one
          case ({1'b0, cfg[i][1:0]})
            pin_cfg_pkg::FN_GPIO_OD: role[i] = pin_cfg_pkg::ROLE_OPEN_DRAIN;
            pin_cfg_pkg::FN_GPIO_PP: role[i] = pin_cfg_pkg::ROLE_PUSH_PULL;
            pin_cfg_pkg::FN_TOGGLE_PP: begin
              role[i] = pin_cfg_pkg::ROLE_PUSH_PULL;
              src[i]  = pin_cfg_pkg::SRC_TOGGLE;
            end
            default: role[i] = pin_cfg_pkg::ROLE_INPUT;
          endcase
        end
        pin_cfg_pkg::SLOT_CARRIER, pin_cfg_pkg::SLOT_ALERT: begin
          case ({1'b0, cfg[i][1:0]})
            pin_cfg_pkg::FN_GPIO_OD: role[i] = pin_cfg_pkg::ROLE_OPEN_DRAIN;
            pin_cfg_pkg::FN_GPIO_PP: role[i] = pin_cfg_pkg::ROLE_PUSH_PULL;
            default: role[i] = pin_cfg_pkg::ROLE_INPUT;
          endcase
        end
        default: begin
          case (cfg[i][2:0])
            pin_cfg_pkg::FN_GPIO_OD: role[i] = pin_cfg_pkg::ROLE_OPEN_DRAIN;
            pin_cfg_pkg::FN_GPIO_PP: role[i] = pin_cfg_pkg::ROLE_PUSH_PULL;
            pin_cfg_pkg::FN_TERM_OD: begin
              role[i] = pin_cfg_pkg::ROLE_OPEN_DRAIN;
              src[i]  = pin_cfg_pkg::SRC_MODEM;
            end
            pin_cfg_pkg::FN_TERM_PP: begin
              role[i] = pin_cfg_pkg::ROLE_PUSH_PULL;
              src[i]  = pin_cfg_pkg::SRC_MODEM;
            end
            default: role[i] = pin_cfg_pkg::ROLE_INPUT;
          endcase
        end
      endcase
    end
  end

  // Drive level comes from the gpio data, the toggle or the UART modem line
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      is_out[i]     = (role[i] != pin_cfg_pkg::ROLE_INPUT);
      open_drain[i] = (role[i] == pin_cfg_pkg::ROLE_OPEN_DRAIN);
      case (src[i])
        pin_cfg_pkg::SRC_TOGGLE: drive_val[i] = toggle_r[i / pin_cfg_pkg::NUM_PINS];
        pin_cfg_pkg::SRC_MODEM:  drive_val[i] = modem_term_ready_n[i / pin_cfg_pkg::NUM_PINS];
        default:                 drive_val[i] = gpio_drive[i];
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pads

  for (genvar g = 0; g < NREG; g++) begin : g_pad
    pin_pad_ctrl u_pad (
      .core_clk   (core_clk),
      .srst       (srst),
      .clk_en     (clk_en),
      .is_out     (is_out[g]),
      .open_drain (open_drain[g]),
      .drive_val  (drive_val[g]),
      .pu_off     (cfg[g][pin_cfg_pkg::WEAK_HIGH_RESISTOR_OFF_BIT]),
      .pd_on      (cfg[g][pin_cfg_pkg::PULL_DOWN_ON_BIT]),
      .pin_in     (pin_in[g]),
      .pin_out    (pin_out[g]),
      .pin_oe     (pin_oe[g]),
      .pu_en      (pin_pull_up[g]),
      .pd_en      (pin_pull_down[g]),
      .in_val     (gpio_sense[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive toggle and call-alert wakeup

  // Toggle runs whatever the role, so the pin shows the current phase on selection
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      toggle_nxt[c] = toggle_r[c] ^ rx_activity[c];
      // A low call-alert input asks for wakeup unless blocked or driven by us
      wake_n_nxt[c] = ~(global_wake_en
        & ~cfg[c*4 + pin_cfg_pkg::SLOT_ALERT][pin_cfg_pkg::ALERT_WAKEUP_BLOCK_BIT]
        & ~is_out[c*4 + pin_cfg_pkg::SLOT_ALERT]
        & ~gpio_sense[c*4 + pin_cfg_pkg::SLOT_ALERT]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      toggle_r <= '0;
      wake_n_r <= '1;
    end else if (clk_en) begin
      toggle_r <= toggle_nxt;
      wake_n_r <= wake_n_nxt;
    end
  end

  assign receive_activity_toggle = toggle_r;
  assign wake_request_n          = wake_n_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
    localparam int T = c * 4;

    toggle_flip_a: assert property (@(posedge core_clk) disable iff (srst)
      (clk_en && rx_activity[c]) |=> (toggle_r[c] != $past(toggle_r[c])))
      else $error("receive toggle did not flip on activity");
    toggle_role_a: assert property (@(posedge core_clk) disable iff (srst)
      (cfg[T][1:0] == 2'h3) |-> (is_out[T] && !open_drain[T] && drive_val[T] == toggle_r[c]))
      else $error("toggle code did not give push-pull toggle output");
    carrier_role_a: assert property (@(posedge core_clk) disable iff (srst)
      (cfg[T+1][1:0] == 2'h1) |-> (is_out[T+1] && open_drain[T+1] && drive_val[T+1] == gpio_drive[T+1]))
      else $error("carrier code 01 is not an open-drain gpio output");
    alert_role_a: assert property (@(posedge core_clk) disable iff (srst)
      (cfg[T+2][1:0] == 2'h0) |-> !is_out[T+2])
      else $error("call-alert code 00 is not an input");
    term_modem_a: assert property (@(posedge core_clk) disable iff (srst)
      (cfg[T+3][2:0] == 3'h4) |-> (is_out[T+3] && !open_drain[T+3] && drive_val[T+3] == modem_term_ready_n[c]))
      else $error("terminal-ready code 100 is not push-pull modem output");
    term_gpio_a: assert property (@(posedge core_clk) disable iff (srst)
      (cfg[T+3][2:0] == 3'h2) |-> (is_out[T+3] && !open_drain[T+3] && drive_val[T+3] == gpio_drive[T+3]))
      else $error("terminal-ready code 010 is not push-pull gpio output");
    wake_block_a: assert property (@(posedge core_clk) disable iff (srst)
      (clk_en && cfg[T+2][5]) |=> wake_request_n[c])
      else $error("wakeup requested while blocked");
    wake_cover_c: cover property (@(posedge core_clk) disable iff (srst)
      $fell(wake_request_n[c]));
    toggle_cover_c: cover property (@(posedge core_clk) disable iff (srst)
      (cfg[T][1:0] == 2'h3) && rx_activity[c] && clk_en);
  end

  read_back_a: assert property (@(posedge core_clk) disable iff (srst)
    (clk_en && reg_wr && reg_addr == 8'h3E) ##1 (clk_en && reg_rd && reg_addr == 8'h3E)
    |=> (reg_rdata == ($past(reg_wdata, 2) & pin_cfg_pkg::MASK_ALERT)))
    else $error("register did not read back what was written");
  reset_zero_a: assert property (@(posedge core_clk)
    srst |=> (cfg[0] == 8'h00 && cfg[7] == 8'h00 && pin_pull_up[0] && !pin_oe[0]))
    else $error("reset did not clear configuration");
  freeze_a: assert property (@(posedge core_clk) disable iff (srst)
    !clk_en |=> $stable(reg_rdata) && $stable(toggle_r))
    else $error("state moved while clock enable was low");
  write_cover_c: cover property (@(posedge core_clk) disable iff (srst)
    reg_wr && clk_en ##1 reg_rd && clk_en);

endmodule
`default_nettype wire
